// File: hw/ivtu_pkg.sv
// Package for the interrupt vector and trap unit: register map, node table, trap codes.
// Assumes a 32-bit APB master and a CPU core that takes one vector at a time.
package ivtu_pkg;
   // Register byte offsets
   localparam logic [11:0] ADDR_VECTOR_SEGMENT_REG = 12'h000;
   localparam logic [11:0] ADDR_CPU_CONTROL_REG_ONE = 12'h004;
   localparam logic [11:0] ADDR_TRAPFLAG = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_TRAPPRIO = 12'h010;
   localparam logic [11:0] ADDR_NODE_BASE = 12'h100;
   // Node control fields
   localparam int NC_PRIO_LSB = 0;
   localparam int NC_PRIO_W = 4;
   localparam int NC_EN_BIT = 6;
   localparam int NC_REQ_BIT = 7;
   // Spacing field in cpu_control_reg_one, bits 1:0, shift = field + 2
   localparam int VSC_LSB = 0;
   localparam int VSC_W = 2;
   localparam logic [1:0] VSC_RESET = 2'h0;
   localparam logic [7:0] VECTOR_SEGMENT_REG_RESET = 8'h00;
   localparam int NUM_NODES = 128;
   localparam int NUM_TRAPS = 8;
   localparam logic [3:0] TRAP_PRIO_RESET = 4'hF;
   // Assigned node trap numbers
   localparam logic [6:0] TN_CAPTURE_RELOAD = 7'h27;
   localparam logic [6:0] TN_ADC_DONE = 7'h28;
   localparam logic [6:0] TN_ADC_OVR = 7'h29;
   localparam logic [6:0] TN_AS0_TX = 7'h2A;
   localparam logic [6:0] TN_AS0_RX = 7'h2B;
   localparam logic [6:0] TN_AS0_ER = 7'h2C;
   localparam logic [6:0] TN_AS0_TB = 7'h47;
   localparam logic [6:0] TN_AS0_AB = 7'h5F;
   localparam logic [6:0] TN_SS0_TX = 7'h2D;
   localparam logic [6:0] TN_SS0_RX = 7'h2E;
   localparam logic [6:0] TN_SS0_ER = 7'h2F;
   localparam logic [6:0] TN_CLKMON = 7'h43;
   localparam logic [6:0] TN_AS1_TX = 7'h48;
   localparam logic [6:0] TN_AS1_RX = 7'h49;
   localparam logic [6:0] TN_AS1_ER = 7'h4A;
   localparam logic [6:0] TN_AS1_TB = 7'h5E;
   localparam logic [6:0] TN_AS1_AB = 7'h42;
   localparam logic [6:0] TN_XFER_END = 7'h4C;
   localparam logic [6:0] TN_SS1_TX = 7'h51;
   localparam logic [6:0] TN_SS1_RX = 7'h52;
   localparam logic [6:0] TN_SS1_ER = 7'h53;
   localparam logic [6:0] TN_RTC = 7'h5D;
   localparam int NUM_SRC = 22;
   // Hardware trap vector trap numbers, indexed by trap flag bit
   localparam logic [6:0] TRAP_TN [NUM_TRAPS] = '{7'h02, 7'h04, 7'h06, 7'h08,
      7'h0A, 7'h0A, 7'h0A, 7'h0A};
   // Fixed class priority of each trap, higher wins
   localparam logic [1:0] TRAP_CLASS [NUM_TRAPS] = '{2'h3, 2'h2, 2'h2, 2'h1,
      2'h0, 2'h0, 2'h0, 2'h0};
   typedef enum logic [1:0] {IVTU_IDLE, IVTU_OFFER, IVTU_WAIT} ivtu_state_t;
endpackage

// File: hw/ivtu_node_mem.sv
// Node control store: one byte per trap number, registered read port.
// Assumes a single writer per cycle; hardware sets merge into the write word.
`timescale 1ns/1ns
module ivtu_node_mem #(
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Registered read port
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem_r [DEPTH];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_r[i] <= 8'h00;
      end
      else if (wr_en)
         mem_r[wr_addr] <= wr_data;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_data <= 8'h00;
      else
         rd_data <= mem_r[rd_addr];
   end
endmodule // ivtu_node_mem

// File: hw/ivtu_prio_scan.sv
// Winner search over the request flags: highest level, lowest trap number on ties.
// Assumes flags and levels are registered; output is combinational.
`timescale 1ns/1ns
module ivtu_prio_scan #(
   parameter int N = 128
) (
   // Inputs per node
   input wire logic [N-1:0] pend,
   input wire logic [N*4-1:0] level,
   // Result
   output logic found,
   output logic [6:0] win_idx,
   output logic [3:0] win_level
);
   always_comb
   begin
      found = 1'b0;
      win_idx = 7'h00;
      win_level = 4'h0;
      for (int i = 0; i < N; i++)
      begin
         // Strict compare keeps the lowest index among equals
         if (pend[i] && (!found || level[i*4 +: 4] > win_level))
         begin
            found = 1'b1;
            win_idx = 7'(i);
            win_level = level[i*4 +: 4];
         end
      end
   end
endmodule // ivtu_prio_scan

// File: hw/ivtu_top.sv
// Interrupt vector and trap unit: node control, arbitration, vector build, hardware traps.
// Assumes an APB master for registers and a CPU core that acknowledges each offered vector.
// Summary of operation
// - Default vector spacing four bytes per trap
// - Vector segment register prefixes every vector address
// - Spacing field scales all vector offsets
// - Capture-reload node trap 27h offset 009Ch
// - Converter nodes traps 28h and 29h
// - First async serial nodes traps 2Ah-2Ch
// - First async buffer 47h, autobaud 5Fh
// - First sync serial nodes traps 2Dh-2Fh
// - Clock monitor node trap 43h offset 010Ch
// - Second async serial nodes traps 48h-4Ah
// - Second async buffer 5Eh, autobaud 42h
// - Transfer end node trap 4Ch offset 0130h
// - Second sync serial nodes traps 51h-53h
// - Real-time clock node trap 5Dh offset 0174h
// - Traps 10h-17h unassigned, software only
// - Other listed gaps unassigned, four-byte spacing
// - Hardware traps unmaskable, own vector except flags 4-7 sharing 0Ah
// - Each trap sets its own flag bit
// - Trap preempts unless same or higher class trap active
// - Node interrupts never preempt trap service
// - Node register holds request, enable, priority
// - Sixteen priority levels per node
// - Accepted service preempted only by higher level or by a hardware trap
// - Software may set request bits directly
`timescale 1ns/1ns
module ivtu_top #(
   parameter int N = ivtu_pkg::NUM_NODES
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral request pulses, one per assigned node
   input wire logic [ivtu_pkg::NUM_SRC-1:0] periph_req,
   // Hardware trap condition pulses
   input wire logic [ivtu_pkg::NUM_TRAPS-1:0] trap_req,
   // CPU side
   input wire logic cpu_ack,
   input wire logic cpu_return,
   output logic vec_valid,
   output logic [23:0] vec_addr,
   output logic [6:0] vec_trap_num,
   output logic vec_is_trap,
   output logic [3:0] cpu_level
);
   // Map of peripheral inputs to trap numbers
   localparam logic [6:0] SRC_TN [ivtu_pkg::NUM_SRC] = '{
      ivtu_pkg::TN_CAPTURE_RELOAD,
      ivtu_pkg::TN_ADC_DONE, ivtu_pkg::TN_ADC_OVR,
      ivtu_pkg::TN_AS0_TX, ivtu_pkg::TN_AS0_RX, ivtu_pkg::TN_AS0_ER,
      ivtu_pkg::TN_AS0_TB, ivtu_pkg::TN_AS0_AB,
      ivtu_pkg::TN_SS0_TX, ivtu_pkg::TN_SS0_RX, ivtu_pkg::TN_SS0_ER,
      ivtu_pkg::TN_CLKMON,
      ivtu_pkg::TN_AS1_TX, ivtu_pkg::TN_AS1_RX, ivtu_pkg::TN_AS1_ER,
      ivtu_pkg::TN_AS1_TB, ivtu_pkg::TN_AS1_AB,
      ivtu_pkg::TN_XFER_END,
      ivtu_pkg::TN_SS1_TX, ivtu_pkg::TN_SS1_RX, ivtu_pkg::TN_SS1_ER,
      ivtu_pkg::TN_RTC};

   // Vector offset from trap number and spacing field
   function automatic logic [15:0] vec_offset(input logic [6:0] tn, input logic [1:0] sc);
      vec_offset = 16'({9'h000, tn} << (5'd2 + 5'(sc)));
   endfunction

   // Node address decode, used by both read and write
   function automatic logic node_hit(input logic [11:0] a);
      node_hit = (a >= ivtu_pkg::ADDR_NODE_BASE)
         && (a < ivtu_pkg::ADDR_NODE_BASE + 12'(N * 4));
   endfunction

   logic [7:0] vector_segment_reg_r;
   logic [1:0] vsc_r;
   logic [ivtu_pkg::NUM_TRAPS-1:0] trap_flag_reg_r;
   logic [ivtu_pkg::NUM_TRAPS*4-1:0] trap_prio_r;
   logic [N-1:0] req_r;
   logic [N-1:0] en_r;
   logic [N*4-1:0] lvl_r;
   logic [N-1:0] assigned;
   logic [N-1:0] hw_set;
   ivtu_pkg::ivtu_state_t state_r;
   logic [3:0] lvl_stack_r [4];
   logic [1:0] sp_r;
   logic in_trap_r;
   logic [1:0] trap_class_r;
   logic [6:0] pend_idx_r;
   logic pend_trap_r;
   logic [2:0] pend_tbit_r;

   logic apb_acc;
   logic apb_wr;
   logic apb_rd;
   logic [6:0] node_idx;
   logic [7:0] mem_rd;
   logic rd_pend_r;
   logic found;
   logic [6:0] win_idx;
   logic [3:0] win_level;
   logic [N-1:0] eligible;

   assign apb_acc = psel && penable && pready;
   assign apb_wr = apb_acc && pwrite;
   assign apb_rd = psel && !penable && !pwrite;
   assign node_idx = 7'(paddr[11:2] - 10'(ivtu_pkg::ADDR_NODE_BASE >> 2));

   // Assigned node mask and hardware set lines
   generate
      for (genvar g = 0; g < N; g++)
      begin : g_node
         always_comb
         begin
            assigned[g] = 1'b0;
            hw_set[g] = 1'b0;
            for (int s = 0; s < ivtu_pkg::NUM_SRC; s++)
            begin
               if (SRC_TN[s] == 7'(g))
               begin
                  assigned[g] = 1'b1;
                  hw_set[g] = periph_req[s];
               end
            end
         end
      end
   endgenerate
   // Unassigned nodes get no hardware line, only software sets

   // APB answers: wait-free, but node reads wait one cycle for the registered memory port
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         rd_pend_r <= 1'b0;
      end
      else
      begin
         rd_pend_r <= apb_rd && node_hit(paddr);
         pready <= (psel && !penable && !(apb_rd && node_hit(paddr))) || rd_pend_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr <= !(node_hit(paddr) || paddr == ivtu_pkg::ADDR_VECTOR_SEGMENT_REG
            || paddr == ivtu_pkg::ADDR_CPU_CONTROL_REG_ONE || paddr == ivtu_pkg::ADDR_TRAPFLAG
            || paddr == ivtu_pkg::ADDR_STATUS || paddr == ivtu_pkg::ADDR_TRAPPRIO)
            || paddr[1:0] != 2'h0;
         unique case (paddr)
            ivtu_pkg::ADDR_VECTOR_SEGMENT_REG: prdata <= {24'h00_0000, vector_segment_reg_r};
            ivtu_pkg::ADDR_CPU_CONTROL_REG_ONE: prdata <= {30'h0000_0000, vsc_r};
            ivtu_pkg::ADDR_TRAPFLAG: prdata <= {24'h00_0000, trap_flag_reg_r};
            ivtu_pkg::ADDR_STATUS: prdata <= {20'h0_0000, in_trap_r, sp_r, found,
               lvl_stack_r[sp_r], 2'(state_r), vec_valid, 1'b0};
            ivtu_pkg::ADDR_TRAPPRIO: prdata <= trap_prio_r;
            default: prdata <= 32'h0000_0000;
         endcase
      end
      else if (rd_pend_r && node_hit(paddr))
         prdata <= {24'h00_0000, req_r[node_idx], mem_rd[6:0]};
   end

   // Shadow copy in the memory only serves APB reads
   ivtu_node_mem #(.DEPTH(N), .AW(7)) u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(apb_wr && node_hit(paddr)),
      .wr_addr(node_idx),
      .wr_data(pwdata[7:0] | {req_r[node_idx], 7'h00}),
      .rd_addr(node_idx),
      .rd_data(mem_rd)
   );

   // Config registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vector_segment_reg_r <= ivtu_pkg::VECTOR_SEGMENT_REG_RESET;
         vsc_r <= ivtu_pkg::VSC_RESET;
         trap_prio_r <= {ivtu_pkg::NUM_TRAPS{ivtu_pkg::TRAP_PRIO_RESET}};
      end
      else if (apb_wr)
      begin
         if (paddr == ivtu_pkg::ADDR_VECTOR_SEGMENT_REG)
            vector_segment_reg_r <= pwdata[7:0];
         if (paddr == ivtu_pkg::ADDR_CPU_CONTROL_REG_ONE)
            vsc_r <= pwdata[ivtu_pkg::VSC_LSB +: ivtu_pkg::VSC_W];
         if (paddr == ivtu_pkg::ADDR_TRAPPRIO)
            trap_prio_r <= pwdata;
      end
   end

   // Node control bits; hardware set beats software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_r <= '0;
         en_r <= '0;
         lvl_r <= '0;
      end
      else
      begin
         if (apb_wr && node_hit(paddr))
         begin
            req_r[node_idx] <= pwdata[ivtu_pkg::NC_REQ_BIT];
            en_r[node_idx] <= pwdata[ivtu_pkg::NC_EN_BIT];
            lvl_r[node_idx*4 +: 4] <= pwdata[ivtu_pkg::NC_PRIO_LSB +: ivtu_pkg::NC_PRIO_W];
         end
         for (int i = 0; i < N; i++)
            if (hw_set[i] && assigned[i])
               req_r[i] <= 1'b1;
         if (state_r == ivtu_pkg::IVTU_OFFER && cpu_ack && !pend_trap_r)
            req_r[pend_idx_r] <= hw_set[pend_idx_r];
      end
   end

   // Trap flags: hardware set, software write-one-to-clear, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trap_flag_reg_r <= '0;
      else
         trap_flag_reg_r <= (trap_flag_reg_r
            & ~((apb_wr && paddr == ivtu_pkg::ADDR_TRAPFLAG) ? pwdata[7:0] : 8'h00))
            | trap_req;
   end
   // Pending traps: each event branches once, the flag stays for software
   logic [ivtu_pkg::NUM_TRAPS-1:0] trap_pend_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trap_pend_r <= '0;
      else
         trap_pend_r <= (trap_pend_r & ~((state_r == ivtu_pkg::IVTU_OFFER && cpu_ack
            && pend_trap_r) ? 8'(1 << pend_tbit_r) : 8'h00)) | trap_req;
   end

   // Only enabled requests above the running level compete
   always_comb
   begin
      for (int i = 0; i < N; i++)
         eligible[i] = req_r[i] && en_r[i] && (lvl_r[i*4 +: 4] > lvl_stack_r[sp_r]);
   end

   ivtu_prio_scan #(.N(N)) u_scan (
      .pend(eligible),
      .level(lvl_r),
      .found(found),
      .win_idx(win_idx),
      .win_level(win_level)
   );

   // Highest class pending trap flag
   logic trap_any;
   logic [2:0] trap_bit;
   always_comb
   begin
      trap_any = 1'b0;
      trap_bit = 3'h0;
      for (int t = 0; t < ivtu_pkg::NUM_TRAPS; t++)
         if (trap_pend_r[t] && (!trap_any
            || ivtu_pkg::TRAP_CLASS[t] > ivtu_pkg::TRAP_CLASS[trap_bit]))
         begin
            trap_any = 1'b1;
            trap_bit = 3'(t);
         end
   end
   logic trap_go;
   // No mask or enable gates a trap; it waits only behind a trap of equal or higher class
   assign trap_go = trap_any && (!in_trap_r
      || ivtu_pkg::TRAP_CLASS[trap_bit] > trap_class_r);

   // Vector offer sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= ivtu_pkg::IVTU_IDLE;
         vec_valid <= 1'b0;
         vec_addr <= 24'h00_0000;
         vec_trap_num <= 7'h00;
         vec_is_trap <= 1'b0;
         pend_idx_r <= 7'h00;
         pend_trap_r <= 1'b0;
         pend_tbit_r <= 3'h0;
      end
      else
      begin
         unique case (state_r)
            ivtu_pkg::IVTU_IDLE:
            begin
               if (trap_go || (found && !in_trap_r))
               begin
                  state_r <= ivtu_pkg::IVTU_OFFER;
                  vec_valid <= 1'b1;
                  pend_trap_r <= trap_go;
                  pend_tbit_r <= trap_bit;
                  pend_idx_r <= trap_go ? ivtu_pkg::TRAP_TN[trap_bit] : win_idx;
                  vec_trap_num <= trap_go ? ivtu_pkg::TRAP_TN[trap_bit] : win_idx;
                  vec_is_trap <= trap_go;
                  vec_addr <= {vector_segment_reg_r, vec_offset(trap_go ? ivtu_pkg::TRAP_TN[trap_bit]
                     : win_idx, vsc_r)};
               end
            end
            ivtu_pkg::IVTU_OFFER:
            begin
               if (cpu_ack)
               begin
                  vec_valid <= 1'b0;
                  state_r <= ivtu_pkg::IVTU_WAIT;
               end
            end
            ivtu_pkg::IVTU_WAIT:
               state_r <= ivtu_pkg::IVTU_IDLE;
         endcase
      end
   end

   // Running level stack and trap state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sp_r <= 2'h0;
         for (int k = 0; k < 4; k++)
            lvl_stack_r[k] <= 4'h0;
         in_trap_r <= 1'b0;
         trap_class_r <= 2'h0;
         cpu_level <= 4'h0;
      end
      else if (state_r == ivtu_pkg::IVTU_OFFER && cpu_ack && sp_r != 2'h3)
      begin
         sp_r <= sp_r + 2'h1;
         lvl_stack_r[sp_r + 2'h1] <= pend_trap_r ? 4'hF : lvl_r[pend_idx_r*4 +: 4];
         cpu_level <= pend_trap_r ? 4'hF : lvl_r[pend_idx_r*4 +: 4];
         if (pend_trap_r)
         begin
            in_trap_r <= 1'b1;
            trap_class_r <= ivtu_pkg::TRAP_CLASS[pend_tbit_r];
         end
      end
      else if (cpu_return && sp_r != 2'h0)
      begin
         // Nested traps leave trap state until the outermost return, a simplification
         sp_r <= sp_r - 2'h1;
         cpu_level <= lvl_stack_r[sp_r - 2'h1];
         if (lvl_stack_r[sp_r - 2'h1] != 4'hF)
            in_trap_r <= 1'b0;
      end
   end
endmodule // ivtu_top

// File: tb/ivtu_monitor.sv
// Checker for the vector and trap unit, bound to ivtu_top.
// Assumes registers change only through the APB port of the unit.
`timescale 1ns/1ns
module ivtu_monitor (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // CPU side
   input wire logic cpu_ack,
   input wire logic vec_valid,
   input wire logic [23:0] vec_addr,
   input wire logic [6:0] vec_trap_num,
   input wire logic vec_is_trap,
   input wire logic [3:0] cpu_level
);
   logic [7:0] seg_r;
   logic [1:0] vsc_r;
   logic node_rd;
   // Node reads take one wait state behind the registered memory port
   assign node_rd = psel && !penable && !pwrite && paddr >= ivtu_pkg::ADDR_NODE_BASE
      && paddr < ivtu_pkg::ADDR_NODE_BASE + 12'h200;
   // Shadow copies, so the vector can be judged from the ports alone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seg_r <= 8'h00;
         vsc_r <= 2'h0;
      end
      else if (psel && penable && pready && pwrite && !pslverr)
      begin
         if (paddr == ivtu_pkg::ADDR_VECTOR_SEGMENT_REG)
            seg_r <= pwdata[7:0];
         if (paddr == ivtu_pkg::ADDR_CPU_CONTROL_REG_ONE)
            vsc_r <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_offer_addr: assert property (vec_valid |->
      vec_addr == {seg_r, 16'({9'h000, vec_trap_num} << (vsc_r + 2))})
      else $error("Vector address not segment plus scaled trap number");
   a_offer_holds: assert property (vec_valid && !cpu_ack |=>
      vec_valid && $stable(vec_addr) && $stable(vec_trap_num))
      else $error("Offer changed before acknowledge");
   a_ack_drops: assert property (vec_valid && cpu_ack |=> !vec_valid)
      else $error("Offer still up after acknowledge");
   a_trap_vector: assert property (vec_valid && vec_is_trap |->
      vec_trap_num inside {7'h02, 7'h04, 7'h06, 7'h08, 7'h0A})
      else $error("Trap offered with a foreign vector");
   a_trap_level: assert property (vec_valid && vec_is_trap && cpu_ack |=>
      cpu_level == 4'hF)
      else $error("Trap service not at top level");
   a_trap_blocks: assert property (cpu_level == 4'hF |->
      !(vec_valid && !vec_is_trap))
      else $error("Node offered during top level service");
   a_node_higher: assert property (vec_valid && !vec_is_trap && cpu_ack |=>
      cpu_level > $past(cpu_level))
      else $error("Node taken without higher level");
   a_apb_answer: assert property ((psel && !penable && !node_rd) |=> pready ##1 !pready)
      else $error("Register access not answered in one cycle");
   a_node_rd_wait: assert property (node_rd |=> !pready ##1 pready ##1 !pready)
      else $error("Node read not answered after one wait state");
endmodule // ivtu_monitor

bind ivtu_top ivtu_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .cpu_ack(cpu_ack), .vec_valid(vec_valid), .vec_addr(vec_addr),
   .vec_trap_num(vec_trap_num), .vec_is_trap(vec_is_trap), .cpu_level(cpu_level));

// File: tb/ivtu_cpu_model.sv
// CPU core model: takes each offered vector after a set delay, ends service on command.
// Assumes the unit holds an offer until acknowledged.
`timescale 1ns/1ns
module ivtu_cpu_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Offer from the unit
   input wire logic vec_valid,
   input wire logic [23:0] vec_addr,
   input wire logic [6:0] vec_trap_num,
   input wire logic vec_is_trap,
   // Bench control
   input wire logic [3:0] ack_dly,
   input wire logic ret_go,
   // Answer to the unit
   output logic cpu_ack,
   output logic cpu_return,
   // Last vector taken
   output int got_cnt,
   output logic [23:0] got_addr,
   output logic [6:0] got_num,
   output logic got_trap
);
   logic [3:0] wait_r;
   // Only a standing offer is taken, and never twice
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_ack <= 1'h0;
         cpu_return <= 1'h0;
         wait_r <= 4'h0;
         got_cnt <= 0;
      end
      else
      begin
         cpu_ack <= 1'h0;
         cpu_return <= ret_go;
         if (vec_valid && !cpu_ack)
         begin
            wait_r <= wait_r + 4'h1;
            if (wait_r == ack_dly)
            begin
               cpu_ack <= 1'h1;
               wait_r <= 4'h0;
               got_cnt <= got_cnt + 1;
               got_addr <= vec_addr;
               got_num <= vec_trap_num;
               got_trap <= vec_is_trap;
            end
         end
      end
   end
endmodule // ivtu_cpu_model

// File: tb/ivtu_top_tb.sv
// Bench for the vector and trap unit: APB tasks set nodes, a CPU model takes vectors.
// Assumes APB answers marked by pready, with one wait state on node reads, and the CPU model beside the unit.
`timescale 1ns/1ns
module ivtu_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ret_go = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic pready, pslverr, e, cpu_ack, cpu_return, vec_valid, vec_is_trap, got_trap;
   logic [21:0] periph_req = '0;
   logic [7:0] trap_req = '0, seg = '0;
   logic [23:0] vec_addr, got_addr;
   logic [6:0] vec_trap_num, got_num, tn;
   logic [3:0] cpu_level, dly = '0, lv;
   int got_cnt, seen = 0, bad_count = 0, compares = 0, sh = 2;
   localparam logic [15:0] OFFS [22] = '{16'h009C, 16'h00A0, 16'h00A4, 16'h00A8, 16'h00AC,
      16'h00B0, 16'h011C, 16'h017C, 16'h00B4, 16'h00B8, 16'h00BC, 16'h010C, 16'h0120,
      16'h0124, 16'h0128, 16'h0178, 16'h0108, 16'h0130, 16'h0144, 16'h0148, 16'h014C,
      16'h0174};
   localparam logic [6:0] TRAPS [8] = '{7'h02, 7'h04, 7'h06, 7'h08, 7'h0A, 7'h0A, 7'h0A,
      7'h0A};
   always #5 pclk = ~pclk;
   ivtu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_req(periph_req), .trap_req(trap_req), .cpu_ack(cpu_ack),
      .cpu_return(cpu_return), .vec_valid(vec_valid), .vec_addr(vec_addr),
      .vec_trap_num(vec_trap_num), .vec_is_trap(vec_is_trap), .cpu_level(cpu_level));
   ivtu_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .vec_valid(vec_valid),
      .vec_addr(vec_addr), .vec_trap_num(vec_trap_num), .vec_is_trap(vec_is_trap),
      .ack_dly(dly), .ret_go(ret_go), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
      .got_cnt(got_cnt), .got_addr(got_addr), .got_num(got_num), .got_trap(got_trap));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic node(input logic [6:0] n, input logic [7:0] v);
      apb(1'h1, ivtu_pkg::ADDR_NODE_BASE + {3'h0, n, 2'h0}, {24'h00_0000, v});
   endtask
   task automatic pulse(input int i, input logic t);
      @(posedge pclk);
      if (t)
         trap_req[i] <= 1'h1;
      else
         periph_req[i] <= 1'h1;
      @(posedge pclk);
      trap_req <= '0;
      periph_req <= '0;
   endtask
   // Count of taken vectors is kept in the CPU model, so an early offer is never missed
   task automatic offer(input logic [6:0] n, input logic tr, input logic [3:0] l);
      logic [15:0] o;
      o = {9'h000, n} << sh;
      repeat (60) if (got_cnt == seen) @(posedge pclk);
      // The level follows the acknowledge by one edge
      @(posedge pclk);
      seen++;
      chk("taken", got_cnt, seen);
      chk("num", got_num, n);
      chk("addr", got_addr, {seg, o});
      chk("trap", got_trap, tr);
      chk("level", cpu_level, l);
   endtask
   task automatic none();
      repeat (20) @(posedge pclk);
      chk("held", got_cnt, seen);
   endtask
   task automatic ret();
      @(posedge pclk);
      ret_go <= 1'h1;
      @(posedge pclk);
      ret_go <= 1'h0;
      repeat (3) @(posedge pclk);
   endtask
   initial
   begin
      #60000;
      bad_count++;
      summarize();
   end
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, ivtu_pkg::ADDR_TRAPPRIO, '0);
      chk("tprio", q, 32'hFFFF_FFFF);
      apb(1'h0, 12'h020, '0);
      chk("slverr", e, 1'h1);
      apb(1'h0, 12'h101, '0);
      chk("unalign", e, 1'h1);
      apb(1'h0, ivtu_pkg::ADDR_VECTOR_SEGMENT_REG, '0);
      chk("seg", q, 32'h0000_0000);
      for (int i = 0; i < 22; i++)
      begin
         dly <= 4'(i % 4);
         tn = OFFS[i][8:2];
         lv = 4'(i % 15 + 1);
         node(tn, 8'h40 | {4'h0, lv});
         pulse(i, 1'h0);
         offer(tn, 1'h0, lv);
         apb(1'h0, ivtu_pkg::ADDR_NODE_BASE + {3'h0, tn, 2'h0}, '0);
         chk("node", q, {24'h00_0000, 8'h40 | {4'h0, lv}});
         ret();
      end
      apb(1'h1, ivtu_pkg::ADDR_VECTOR_SEGMENT_REG, 32'h0000_005A);
      seg = 8'h5A;
      apb(1'h1, ivtu_pkg::ADDR_CPU_CONTROL_REG_ONE, 32'h0000_0001);
      sh = 3;
      node(7'h10, 8'hC3);
      offer(7'h10, 1'h0, 4'h3);
      ret();
      apb(1'h1, ivtu_pkg::ADDR_CPU_CONTROL_REG_ONE, 32'h0000_0000);
      sh = 2;
      node(7'h5C, 8'hC2);
      offer(7'h5C, 1'h0, 4'h2);
      ret();
      node(7'h13, 8'hC0);
      none();
      node(7'h11, 8'hC9);
      offer(7'h11, 1'h0, 4'h9);
      node(7'h50, 8'hC5);
      node(7'h4D, 8'hC5);
      none();
      ret();
      offer(7'h4D, 1'h0, 4'h5);
      node(7'h40, 8'hC5);
      none();
      node(7'h41, 8'hC6);
      offer(7'h41, 1'h0, 4'h6);
      ret();
      none();
      ret();
      offer(7'h40, 1'h0, 4'h5);
      ret();
      offer(7'h50, 1'h0, 4'h5);
      ret();
      for (int k = 0; k < 8; k++)
      begin
         pulse(k, 1'h1);
         offer(TRAPS[k], 1'h1, 4'hF);
         apb(1'h0, ivtu_pkg::ADDR_TRAPFLAG, '0);
         chk("flags", q, (32'h1 << (k + 1)) - 1);
         ret();
      end
      apb(1'h1, ivtu_pkg::ADDR_TRAPFLAG, 32'h0000_00FF);
      apb(1'h0, ivtu_pkg::ADDR_TRAPFLAG, '0);
      chk("clear", q, 32'h0000_0000);
      pulse(3, 1'h1);
      offer(7'h08, 1'h1, 4'hF);
      node(7'h12, 8'hCF);
      none();
      pulse(0, 1'h1);
      offer(7'h02, 1'h1, 4'hF);
      ret();
      ret();
      offer(7'h12, 1'h0, 4'hF);
      pulse(2, 1'h1);
      offer(7'h06, 1'h1, 4'hF);
      ret();
      ret();
      summarize();
   end
endmodule // ivtu_top_tb
